// ===== hw/pscg_pkg.sv
// package: constants, types and carriers of the poll sequencer
// What this block does
// [RULE1] repoll or advance enters first-char state
// [RULE2] first-char state starts the distributor
// [RULE3] first cycle done moves to second char
// [RULE4] second cycle done ends the start code
// [RULE5] stored call code plus 1.0 s idle sends asterisk
// [RULE6] first cycle done moves asterisk to acknowledge
// [RULE7] second cycle done clears acknowledge
// [RULE8] advance steps one station, request self-clears
// [RULE9] settled drops while stepping, returns after 30 ms
// [RULE10] settled reasserted when first-char state clears
// [RULE11] skipped position advances again at once
// [RULE12] stations 1 to 25, position 26 ends cycle
// [RULE13] position 26 rests: no start code sent
// [RULE14] no advance while first-char state is set
// [RULE15] break clears first-char, EOT then advances
// [RULE16] received call code latches continue polling
// [RULE17] continue polling jumps 26 to 1, then clears
// [RULE18] break 0.300 s, EOT after 0.200 s pause
// [RULE19] character cycle is 300 ms over three
// [RULE20] synchronous reset clears states, position 26
// [RULE21] cycle, idle and code inputs from neighbours; the cycle ends come from the internal character timer and are outputs
package pscg_pkg;
  localparam int unsigned CLK_HZ    = 20_000_000;
  localparam int unsigned SETTLE_MS = 30;
  localparam int unsigned IDLE_MS   = 1000;
  localparam int unsigned BRKSEQ_MS = 300;
  localparam int unsigned BREAK_MS  = 300;
  localparam int unsigned PAUSE_MS  = 200;
  localparam int unsigned CHAR_MS   = BRKSEQ_MS / 3;
  localparam int unsigned MS_CYC    = CLK_HZ / 1000;
  localparam int unsigned SETTLE_CYC = SETTLE_MS * MS_CYC;
  localparam int unsigned IDLE_CYC   = IDLE_MS * MS_CYC;
  localparam int unsigned CHAR_CYC   = CHAR_MS * MS_CYC;
  localparam int unsigned BREAK_CHR  = BREAK_MS / CHAR_MS;
  localparam int unsigned PAUSE_CHR  = PAUSE_MS / CHAR_MS;

  localparam int unsigned NUM_STN = 25;
  localparam int unsigned POS_W   = 5;
  localparam logic [4:0]  FIRST_POS = 5'h01;
  localparam logic [4:0]  END_POS   = 5'h1a;
  localparam logic [2:0]  TSC_LEN   = 3'h2;
  localparam logic [2:0]  BRK_LEN   = 3'(BREAK_CHR + PAUSE_CHR + 1);

  localparam int unsigned ADDR_W   = 8;
  localparam logic [7:0]  CTRL_OFS = 8'h00;
  localparam logic [7:0]  SKIP_OFS = 8'h04;
  localparam logic [7:0]  STAT_OFS = 8'h08;
  localparam int unsigned CTRL_REPOLL = 0;
  localparam int unsigned CTRL_ADV    = 1;
  localparam int unsigned CTRL_BREAK  = 2;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_TSC, SEQ_ACK, SEQ_BRK} pscg_seq_e;
  typedef enum logic [2:0] {
    CH_NONE, CH_FIRST_START, CH_SECOND_START, CH_ASTERISK, CH_ACK,
    CH_BREAK, CH_PAUSE, CH_EOT
  } pscg_char_e;

  typedef struct packed {
    logic brk;
    logic advance;
    logic repoll;
  } pscg_cmd_s;

  typedef struct packed {
    logic       line_break;
    logic       busy;
    logic       continue_polling;
    logic       stepper_settled;
    logic       ack_state;
    logic       asterisk_state;
    logic       second_char_state;
    logic       first_char_state;
    logic [2:0] spare;
    logic [4:0] poll_pos;
  } pscg_stat_s;
endpackage

// ===== hw/pscg_timer.sv
// one-shot cycle timer: done pulse LEN cycles after restart
`timescale 1ns/10ps
module pscg_timer #(
  parameter int unsigned LEN = 2
) (
  input  wire logic aclk,     // system clock
  input  wire logic aresetn,  // sync reset, active low
  input  wire logic restart,  // load and start counting
  output logic      done,     // pulse at the end of the count
  output logic      expired   // level from done until restart
);
  localparam int unsigned W = $clog2(LEN + 1);
  logic [W-1:0] cnt_q;
  logic         act_q;

  assign done = act_q && (cnt_q == '0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      act_q <= 1'b0;
    end else if (restart) begin
      cnt_q <= W'(LEN - 1);
      act_q <= 1'b1;
    end else if (done) begin
      act_q <= 1'b0;
    end else if (act_q) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      expired <= 1'b0;
    end else if (done) begin
      expired <= 1'b1;
    end
  end
endmodule

// ===== hw/pscg_axil.sv
// axi4-lite slave: command, skip and status registers
`timescale 1ns/10ps
module pscg_axil
  import pscg_pkg::*;
(
  input  wire logic                 aclk,      // system clock
  input  wire logic                 aresetn,   // sync reset, active low
  input  wire logic [ADDR_W-1:0]    awaddr,    // write address
  input  wire logic                 awvalid,   // write address valid
  output logic                      awready,   // write address taken
  input  wire logic [31:0]          wdata,     // write data
  input  wire logic [3:0]           wstrb,     // byte lanes
  input  wire logic                 wvalid,    // write data valid
  output logic                      wready,    // write data taken
  output logic [1:0]                bresp,     // write response
  output logic                      bvalid,    // write response valid
  input  wire logic                 bready,    // write response taken
  input  wire logic [ADDR_W-1:0]    araddr,    // read address
  input  wire logic                 arvalid,   // read address valid
  output logic                      arready,   // read address taken
  output logic [31:0]               rdata,     // read data
  output logic [1:0]                rresp,     // read response
  output logic                      rvalid,    // read data valid
  input  wire logic                 rready,    // read data taken
  input  wire pscg_pkg::pscg_stat_s stat,      // block state
  output pscg_pkg::pscg_cmd_s       cmd,       // one-cycle commands
  output logic [NUM_STN-1:0]        skip_mask  // per-station skip
);
  logic [ADDR_W-1:0] wa;
  logic [ADDR_W-1:0] ra;
  logic              wr_hs;
  logic              rd_hs;

  assign wa    = {awaddr[ADDR_W-1:2], 2'h0};
  assign ra    = {araddr[ADDR_W-1:2], 2'h0};
  assign wr_hs = awready && awvalid && wvalid;
  assign rd_hs = arready && arvalid;

  // address and data are taken together, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
    end else begin
      awready <= awvalid && wvalid && !awready && !bvalid;
      wready  <= awvalid && wvalid && !awready && !bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_hs) begin
      bvalid <= 1'b1;
      bresp  <= (wa == CTRL_OFS || wa == SKIP_OFS || wa == STAT_OFS) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd       <= '0;
      skip_mask <= '0;
    end else begin
      cmd <= '0;
      if (wr_hs && wa == CTRL_OFS && wstrb[0]) begin
        cmd.repoll  <= wdata[CTRL_REPOLL];
        cmd.advance <= wdata[CTRL_ADV];
        cmd.brk     <= wdata[CTRL_BREAK];
      end
      if (wr_hs && wa == SKIP_OFS) begin
        for (int b = 0; b < NUM_STN; b++) begin
          if (wstrb[b / 8]) begin
            skip_mask[b] <= wdata[b];
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
    end else begin
      arready <= arvalid && !arready && !rvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= RESP_OKAY;
    end else if (rd_hs) begin
      rvalid <= 1'b1;
      rresp  <= RESP_OKAY;
      case (ra)
        CTRL_OFS: rdata <= 32'h0;
        SKIP_OFS: rdata <= {7'h0, skip_mask};
        STAT_OFS: rdata <= {16'h0, stat};
        default: begin
          rdata <= 32'h0;
          rresp <= RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

// ===== hw/pscg_top.sv
// poll sequencer: start codes, response, poll position stepping
`timescale 1ns/10ps
module pscg_top
  import pscg_pkg::*;
#(
  parameter int unsigned SETTLE_LEN = SETTLE_CYC,
  parameter int unsigned IDLE_LEN   = IDLE_CYC,
  parameter int unsigned CHAR_LEN   = CHAR_CYC
) (
  input  wire logic              aclk,               // system clock
  input  wire logic              aresetn,            // sync reset, active low
  input  wire logic [ADDR_W-1:0] awaddr,             // axi write address
  input  wire logic              awvalid,            // axi write address valid
  output logic                   awready,            // axi write address ready
  input  wire logic [31:0]       wdata,              // axi write data
  input  wire logic [3:0]        wstrb,              // axi byte lanes
  input  wire logic              wvalid,             // axi write data valid
  output logic                   wready,             // axi write data ready
  output logic [1:0]             bresp,              // axi write response
  output logic                   bvalid,             // axi write response valid
  input  wire logic              bready,             // axi write response ready
  input  wire logic [ADDR_W-1:0] araddr,             // axi read address
  input  wire logic              arvalid,            // axi read address valid
  output logic                   arready,            // axi read address ready
  output logic [31:0]            rdata,              // axi read data
  output logic [1:0]             rresp,              // axi read response
  output logic                   rvalid,             // axi read data valid
  input  wire logic              rready,             // axi read data ready
  input  wire logic              line_idle_timer,    // line idle level
  input  wire logic              call_code_stored,   // call code held
  input  wire logic              call_code_received, // call code pulse
  output logic [POS_W-1:0]       poll_pos,           // poll position
  output logic                   first_char_state,   // first start char
  output logic                   second_char_state,  // second start char
  output logic                   asterisk_state,     // asterisk sending
  output logic                   ack_state,          // acknowledge
  output logic                   stepper_settled,    // position settled
  output logic                   continue_polling,   // skip poll rest
  output logic                   dist_run,           // distributor busy
  output logic                   line_break,         // line held open
  output pscg_pkg::pscg_char_e   tx_char,            // char on the line
  output logic                   first_cycle_done,   // end of cycle 1
  output logic                   second_cycle_done   // end of cycle 2
);
  import pscg_pkg::*;

  function automatic logic stn_skipped(input logic [POS_W-1:0] p,
                                       input logic [NUM_STN-1:0] m);
    logic hit;
    hit = 1'b0;
    if (p >= FIRST_POS && p < END_POS) begin
      hit = m[p - FIRST_POS];
    end
    return hit;
  endfunction

  function automatic pscg_char_e char_of(input pscg_seq_e s,
                                         input logic [2:0] c);
    pscg_char_e ch;
    ch = CH_NONE;
    case (s)
      SEQ_TSC: ch = (c == 3'h0) ? CH_FIRST_START : CH_SECOND_START;
      SEQ_ACK: ch = (c == 3'h0) ? CH_ASTERISK : CH_ACK;
      SEQ_BRK: begin
        if (c < 3'(BREAK_CHR)) begin
          ch = CH_BREAK;
        end else if (c < 3'(BREAK_CHR + PAUSE_CHR)) begin
          ch = CH_PAUSE;
        end else begin
          ch = CH_EOT;
        end
      end
      default: ch = CH_NONE;
    endcase
    return ch;
  endfunction

  pscg_cmd_s          cmd;
  pscg_stat_s         stat;
  logic [NUM_STN-1:0] skip_mask;

  pscg_seq_e  seq_q;
  logic [2:0] cyc_q;
  logic       adv_req_q;
  logic       brk_req_q;

  logic settle_done;
  logic idle_expired;
  logic char_done;
  logic adv_take;
  logic skip_step;
  logic cont_step;
  logic step_now;
  logic tsc_go;
  logic ast_go;
  logic brk_go;
  logic dist_go;
  logic seq_more;
  logic seq_end;
  logic cyc1_end;
  logic cyc2_end;
  logic eot_end;
  logic [2:0] cyc_next;

  // an advance is only taken once the first-char state has dropped
  assign adv_take  = adv_req_q && !first_char_state;             // [RULE14]
  assign skip_step = !stepper_settled && stn_skipped(poll_pos, skip_mask); // [RULE11]
  assign cont_step = (poll_pos == END_POS) && continue_polling;  // [RULE17]
  assign step_now  = adv_take || skip_step || cont_step;

  assign cyc_next = cyc_q + 3'h1;
  assign seq_end  = char_done &&
                    (cyc_next == ((seq_q == SEQ_BRK) ? BRK_LEN : TSC_LEN));
  assign seq_more = char_done && !seq_end;
  assign cyc1_end = char_done && (cyc_next == 3'h1);
  assign cyc2_end = char_done && (cyc_next == 3'h2);
  assign eot_end  = seq_end && (seq_q == SEQ_BRK);

  // position 26 never starts a start code, so it rests there
  assign tsc_go = first_char_state && stepper_settled && !step_now &&
                  (poll_pos != END_POS) && !second_char_state; // [RULE2] [RULE13]
  assign ast_go = call_code_stored && idle_expired &&
                  !asterisk_state && !ack_state;               // [RULE5]
  assign brk_go = brk_req_q;
  assign dist_go = (seq_q == SEQ_IDLE) && (brk_go || tsc_go || ast_go);

  pscg_axil u_axil (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .awaddr    (awaddr),
    .awvalid   (awvalid),
    .awready   (awready),
    .wdata     (wdata),
    .wstrb     (wstrb),
    .wvalid    (wvalid),
    .wready    (wready),
    .bresp     (bresp),
    .bvalid    (bvalid),
    .bready    (bready),
    .araddr    (araddr),
    .arvalid   (arvalid),
    .arready   (arready),
    .rdata     (rdata),
    .rresp     (rresp),
    .rvalid    (rvalid),
    .rready    (rready),
    .stat      (stat),
    .cmd       (cmd),
    .skip_mask (skip_mask)
  );

  // release delay of the stepper after the last step
  pscg_timer #(.LEN(SETTLE_LEN)) u_settle (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (step_now),
    .done    (settle_done),
    .expired ()
  );

  // own transmission keeps the idle timer from running
  pscg_timer #(.LEN(IDLE_LEN)) u_idle (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (!line_idle_timer || dist_run || ast_go),         // [RULE21]
    .done    (),
    .expired (idle_expired)
  );

  // distributor character cycle, a third of the break time
  pscg_timer #(.LEN(CHAR_LEN)) u_char (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (dist_go || seq_more),                            // [RULE19]
    .done    (char_done),
    .expired ()
  );

  always_comb begin
    stat                   = '0;
    stat.poll_pos          = poll_pos;
    stat.first_char_state  = first_char_state;
    stat.second_char_state = second_char_state;
    stat.asterisk_state    = asterisk_state;
    stat.ack_state         = ack_state;
    stat.stepper_settled   = stepper_settled;
    stat.continue_polling  = continue_polling;
    stat.busy              = dist_run;
    stat.line_break        = line_break;
  end

  // requests: a new one in the taking cycle is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adv_req_q <= 1'b0;
      brk_req_q <= 1'b0;
    end else begin
      adv_req_q <= cmd.advance || eot_end || (adv_req_q && !adv_take); // [RULE8] [RULE15]
      brk_req_q <= cmd.brk || (brk_req_q && !(dist_go && brk_go));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      poll_pos <= END_POS;                                     // [RULE20]
    end else if (cont_step) begin
      poll_pos <= FIRST_POS;                                   // [RULE17]
    end else if (step_now) begin
      // 26 is the end marker, one past the last station
      poll_pos <= (poll_pos == END_POS) ? FIRST_POS : poll_pos + 5'h01; // [RULE8] [RULE12]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      continue_polling <= 1'b0;
    end else if (call_code_received) begin
      continue_polling <= 1'b1;                                // [RULE16]
    end else if (cont_step) begin
      continue_polling <= 1'b0;                                // [RULE17]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stepper_settled <= 1'b1;
    end else if (step_now) begin
      stepper_settled <= 1'b0;                                 // [RULE9]
    end else if (settle_done || (first_char_state && cyc1_end)) begin
      stepper_settled <= 1'b1;                                 // [RULE9] [RULE10]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_char_state <= 1'b0;                                // [RULE20]
    end else if (adv_take || (cmd.repoll && !first_char_state)) begin
      first_char_state <= 1'b1;                                // [RULE1]
    end else if (cyc1_end && seq_q == SEQ_TSC) begin
      first_char_state <= 1'b0;                                // [RULE3]
    end else if (cyc2_end && seq_q == SEQ_BRK) begin
      first_char_state <= 1'b0;                                // [RULE15]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      second_char_state <= 1'b0;
    end else if (cyc1_end && seq_q == SEQ_TSC) begin
      second_char_state <= 1'b1;                               // [RULE3]
    end else if (cyc2_end && seq_q == SEQ_TSC) begin
      second_char_state <= 1'b0;                               // [RULE4]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      asterisk_state <= 1'b0;
      ack_state      <= 1'b0;
    end else if (dist_go && !brk_go && !tsc_go) begin
      asterisk_state <= 1'b1;                                  // [RULE5]
    end else if (cyc1_end && seq_q == SEQ_ACK) begin
      asterisk_state <= 1'b0;                                  // [RULE6]
      ack_state      <= 1'b1;
    end else if (cyc2_end && seq_q == SEQ_ACK) begin
      ack_state      <= 1'b0;                                  // [RULE7]
    end
  end

  // break has priority, then start codes, then the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_q <= SEQ_IDLE;
      cyc_q <= 3'h0;
    end else if (dist_go) begin
      seq_q <= brk_go ? SEQ_BRK : (tsc_go ? SEQ_TSC : SEQ_ACK);
      cyc_q <= 3'h0;
    end else if (seq_end) begin
      seq_q <= SEQ_IDLE;
      cyc_q <= 3'h0;
    end else if (char_done) begin
      cyc_q <= cyc_next;                                       // [RULE18]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dist_run          <= 1'b0;
      tx_char           <= CH_NONE;
      line_break        <= 1'b0;
      first_cycle_done  <= 1'b0;
      second_cycle_done <= 1'b0;
    end else begin
      first_cycle_done  <= cyc1_end;                           // [RULE19]
      second_cycle_done <= cyc2_end;
      if (dist_go) begin
        dist_run   <= 1'b1;
        tx_char    <= brk_go ? CH_BREAK : (tsc_go ? CH_FIRST_START : CH_ASTERISK);
        line_break <= brk_go;                                  // [RULE18]
      end else if (seq_end) begin
        dist_run   <= 1'b0;
        tx_char    <= CH_NONE;
        line_break <= 1'b0;
      end else if (char_done) begin
        tx_char    <= char_of(seq_q, cyc_next);
        line_break <= (char_of(seq_q, cyc_next) == CH_BREAK);  // [RULE18]
      end
    end
  end
endmodule

// ===== tb/pscg_top_asserts.sv
// checker: timing of the poll sequencer outputs
`timescale 1ns/10ps
module pscg_chk
  import pscg_pkg::*;
#(
  parameter int unsigned SETTLE_LEN = 20,
  parameter int unsigned IDLE_LEN   = 50,
  parameter int unsigned CHAR_LEN   = 10
) (
  input wire logic                 aclk,              // clock
  input wire logic                 aresetn,           // reset
  input wire logic                 line_idle_timer,   // idle
  input wire logic                 call_code_stored,  // held code
  input wire logic [POS_W-1:0]     poll_pos,          // position
  input wire logic                 first_char_state,  // char 1
  input wire logic                 second_char_state, // char 2
  input wire logic                 asterisk_state,    // asterisk
  input wire logic                 stepper_settled,   // settled
  input wire logic                 continue_polling,  // cp
  input wire logic                 dist_run,          // busy
  input wire pscg_pkg::pscg_char_e tx_char,           // char
  input wire logic                 second_cycle_done  // cycle end
);
  localparam int SLO = SETTLE_LEN - 3;
  localparam int SHI = SETTLE_LEN + 1;
  localparam int CLO = CHAR_LEN - 1;
  localparam int CHI = CHAR_LEN + 1;
  localparam int ILO = IDLE_LEN - 3;
  logic        up_q;
  logic [15:0] still_q;
  logic [15:0] idle_q;
  // past values from inside reset are not trusted
  always_ff @(posedge aclk) up_q <= aresetn;
  always_ff @(posedge aclk) still_q <= (!aresetn || $changed(poll_pos)) ? 16'h0 : still_q + 16'h1;
  always_ff @(posedge aclk) idle_q <= (!aresetn || !line_idle_timer) ? 16'h0 : idle_q + 16'h1;
  default clocking dcb @(posedge aclk); endclocking
  default disable iff (!aresetn || !up_q);
  a_reset_vals: assert property (disable iff (1'b0)
    !aresetn |=> poll_pos == END_POS && stepper_settled && !first_char_state && !dist_run)
    else $error("bad reset state");
  a_char_order: assert property ($rose(second_char_state) |-> $fell(first_char_state))
    else $error("second char out of order");
  a_tsc_len: assert property ($rose(second_char_state) |-> ##[CLO:CHI] $fell(second_char_state))
    else $error("char cycle length");
  a_tsc_end: assert property ($fell(second_char_state) |-> ##[0:1] second_cycle_done)
    else $error("no second cycle end");
  a_ast_cause: assert property ($rose(asterisk_state) |-> call_code_stored && idle_q >= ILO)
    else $error("asterisk without idle code");
  a_step_one: assert property ($changed(poll_pos) && $past(poll_pos) != END_POS
    |-> poll_pos == $past(poll_pos) + 5'h1)
    else $error("step not by one");
  a_settle_time: assert property ($rose(stepper_settled) |-> still_q >= SLO && still_q <= SHI)
    else $error("settle delay");
  a_start_gate: assert property ($rose(tx_char == CH_FIRST_START)
    |-> first_char_state && stepper_settled && dist_run && poll_pos != END_POS)
    else $error("start code not gated");
  a_cp_wrap: assert property ($rose(poll_pos == END_POS) && continue_polling
    |-> ##[1:2] poll_pos == FIRST_POS)
    else $error("no wrap to first");
  c_rest: cover property (poll_pos == END_POS && first_char_state && !dist_run);
  c_wrap: cover property (continue_polling && poll_pos == END_POS);
  c_resp: cover property ($rose(asterisk_state));
endmodule

bind pscg_top pscg_chk #(.SETTLE_LEN(SETTLE_LEN), .IDLE_LEN(IDLE_LEN), .CHAR_LEN(CHAR_LEN))
  u_chk (.aclk, .aresetn, .line_idle_timer, .call_code_stored, .poll_pos, .first_char_state,
  .second_char_state, .asterisk_state, .stepper_settled, .continue_polling, .dist_run,
  .tx_char, .second_cycle_done);

// ===== tb/pscg_line_model.sv
// line model: idle sensing and call codes from remote stations
`timescale 1ns/10ps
module pscg_line_model (
  input  wire logic aclk,               // clock
  input  wire logic aresetn,            // reset
  input  wire logic dist_run,           // sending
  input  wire logic ack_state,          // ack sent
  input  wire logic want_store,         // hold a code
  input  wire logic want_rx,            // hear a code
  output logic      line_idle_timer,    // line idle
  output logic      call_code_stored,   // code held
  output logic      call_code_received  // code pulse
);
  logic ack_q;
  // line is idle only while nothing is sent; the ack consumes the code
  always_ff @(posedge aclk) begin
    ack_q <= ack_state;
    line_idle_timer <= !dist_run;
    call_code_received <= want_rx;
    if (!aresetn || (ack_q && !ack_state)) call_code_stored <= 1'b0;
    else if (want_store) call_code_stored <= 1'b1;
  end
endmodule

// ===== tb/pscg_top_tb.sv
// testbench: bus access, start codes, skipping, rest, break, response
`timescale 1ns/10ps
module pscg_top_tb;
  import pscg_pkg::*;
  logic        aclk, awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic        aresetn = '0, want_store = '0, want_rx = '0;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, mask;
  logic        awready, wready, bvalid, arready, rvalid, first_cycle_done, second_cycle_done;
  logic [1:0]  bresp, rresp;
  logic [4:0]  poll_pos;
  logic        line_idle_timer, call_code_stored, call_code_received, first_char_state;
  logic        second_char_state, asterisk_state, ack_state, stepper_settled;
  logic        continue_polling, dist_run, line_break;
  pscg_char_e  tx_char, last_c = CH_NONE, chr_q[$];
  logic [33:0] bus_q[$];
  int          fails = 0, checks_done = 0;

  pscg_top #(.SETTLE_LEN(20), .IDLE_LEN(50), .CHAR_LEN(10)) dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .line_idle_timer, .call_code_stored, .call_code_received, .poll_pos, .first_char_state,
    .second_char_state, .asterisk_state, .ack_state, .stepper_settled, .continue_polling,
    .dist_run, .line_break, .tx_char, .first_cycle_done, .second_cycle_done);
  pscg_line_model u_line (.aclk, .aresetn, .dist_run, .ack_state, .want_store, .want_rx,
    .line_idle_timer, .call_code_stored, .call_code_received);

  initial begin
    aclk = '0;
    forever #25 aclk = ~aclk;
  end

  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("Error at %0t: saw %h, want %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bus_q.push_back({r, 32'h0});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
    bus_q.push_back({r, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask

  // let the command land, then wait for all due chars and a settled stepper
  task automatic quiet();
    repeat (3) @(posedge aclk);
    while (chr_q.size() != 0 || dist_run || !stepper_settled) @(posedge aclk);
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    if (rvalid && rready) chk({rresp, rdata}, bus_q.pop_front());
    if (bvalid && bready) chk({bresp, 32'h0}, bus_q.pop_front());
    if (tx_char != last_c && tx_char != CH_NONE) begin
      if (chr_q.size() == 0) chk(34'(tx_char), 34'h0);
      else chk(34'(tx_char), 34'(chr_q.pop_front()));
    end
    last_c = tx_char;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    report_and_stop();
  end

  initial begin
    void'($urandom(29));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(STAT_OFS, RESP_OKAY, 32'h101a);
    rd(8'h0c, RESP_SLVERR, 32'h0);
    wr(8'h10, 32'h1, RESP_SLVERR);
    rd(CTRL_OFS, RESP_OKAY, 32'h0);
    mask = ($urandom() & 32'h01fffff8) | 32'h3;
    wr(SKIP_OFS, mask, RESP_OKAY);
    rd(SKIP_OFS, RESP_OKAY, mask);
    // advance from rest, then repoll station 3
    for (int i = 2; i > 0; i--) begin
      chr_q = {CH_FIRST_START, CH_SECOND_START};
      wr(CTRL_OFS, 32'(i), RESP_OKAY);
      quiet();
      rd(STAT_OFS, RESP_OKAY, 32'h1003);
    end
    wr(SKIP_OFS, 32'h01fffffb, RESP_OKAY);
    wr(CTRL_OFS, 32'h2, RESP_OKAY);
    quiet();
    rd(STAT_OFS, RESP_OKAY, 32'h111a);
    chr_q = {CH_BREAK, CH_PAUSE, CH_EOT, CH_FIRST_START, CH_SECOND_START};
    wr(CTRL_OFS, 32'h4, RESP_OKAY);
    quiet();
    rd(STAT_OFS, RESP_OKAY, 32'h1003);
    want_rx <= 1'b1;
    @(posedge aclk);
    want_rx <= 1'b0;
    rd(STAT_OFS, RESP_OKAY, 32'h3003);
    chr_q = {CH_FIRST_START, CH_SECOND_START};
    wr(CTRL_OFS, 32'h2, RESP_OKAY);
    quiet();
    rd(STAT_OFS, RESP_OKAY, 32'h1003);
    chr_q = {CH_ASTERISK, CH_ACK};
    want_store <= 1'b1;
    @(posedge aclk);
    want_store <= 1'b0;
    quiet();
    rd(STAT_OFS, RESP_OKAY, 32'h1003);
    report_and_stop();
  end
endmodule
